/* logic/vbi_slicer_config_access.sv */
// VBI slicer line-mode, config RAM and result access over the serial control port
`timescale 1ns/1ns
`include "vbi_slicer_params.svh"

module vbi_slicer_config_access (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire vbi_slicer_pkg::vpos_s vpos_i,
	input wire vbi_slicer_pkg::beat_s beat_i,
	output vbi_slicer_pkg::slice_ctl_s slice_ctl_o,
	input wire logic [7:0] cram_raddr_i,
	output logic [7:0] cram_rdata_o,
	output logic cram_host_own_o
);
	import vbi_slicer_pkg::*;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_f;
		logic sda_f;
		ser_state_e st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic sda_oe;
		logic sda_out;
		logic [7:0] cram_ptr;
		logic [7:0] sample_ctrl;
		logic [`LINE_REGS-1:0][7:0] line_mode;
		slice_ctl_s slice_ctl;
		logic host_own;
	} state_s;

	state_s q, d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [7:0] cram [`CRAM_DEPTH];
	logic [7:0] cram_rdata_q;
	logic scl_n, sda_n, rise, fall, start, stop, load_rd;
	logic cram_we, fifo_pop;
	logic [7:0] rd_byte, res_rd, fifo_head;
	logic fifo_empty;
	logic [5:0] cur_idx;
	logic cur_in_range;
	logic [3:0] cur_code;
	svc_e cur_svc;
	logic wr_fifo, wr_reg;

	// Service picked by a line-mode code under the current sampling setting
	function automatic svc_e svc_decode(input logic [7:0] mode, input logic sample);
		svc_e s;
		if (mode == `LINE_MODE_OFF) begin
			s = SVC_OFF;
		end else if (mode[3:0] == `CODE_FULL) begin
			s = SVC_FULL;
		end else if (!sample) begin
			s = SVC_RESERVED;
		end else if (mode[3:0] <= `CODE_TT_LAST) begin
			s = SVC_TELETEXT;
		end else if (mode[3:0] <= `CODE_DATA_LAST) begin
			s = SVC_REGDATA;
		end else begin
			s = SVC_RESERVED;
		end
		return s;
	endfunction

	// Line-mode register index for a VBI line, field 2 after field 1
	function automatic logic [5:0] line_index(input vpos_s p);
		logic [5:0] base;
		base = 6'(p.line - `VBI_LINE_FIRST);
		return p.field ? base + `VBI_LINES_PER_FIELD : base;
	endfunction

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
			input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// Reset released through two flops
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Service lookup for the line being sliced
	assign cur_in_range = (vpos_i.line >= `VBI_LINE_FIRST) && (vpos_i.line <= `VBI_LINE_LAST);
	assign cur_idx = line_index(vpos_i);
	// Index runs past the register file off the slicing range, so keep the code clean there
	assign cur_code = cur_in_range ? q.line_mode[cur_idx][3:0] : 4'h0;
	assign cur_svc = cur_in_range ?
		svc_decode(q.line_mode[cur_idx], q.sample_ctrl[`SAMPLE_BIT]) : SVC_OFF;
	// Reserved or idle lines never reach either store
	assign wr_fifo = beat_i.valid && (cur_svc == SVC_TELETEXT || cur_svc == SVC_REGDATA
		|| cur_svc == SVC_FULL);
	assign wr_reg = beat_i.valid && cur_svc == SVC_REGDATA;

	slicer_result_store u_store (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.clk_en_i(clk_en_i),
		.wr_fifo_i(wr_fifo),
		.wr_reg_i(wr_reg),
		.reg_idx_i(beat_i.offset),
		.data_i(beat_i.data),
		.reg_ra_i(5'(q.ptr - `OFS_RESULT_FIRST)),
		.reg_rd_o(res_rd),
		.fifo_pop_i(fifo_pop),
		.fifo_head_o(fifo_head),
		.fifo_empty_o(fifo_empty)
	);

	// Filtered pin levels: change taken once second and third stages agree
	assign scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
	assign sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
	assign rise = scl_n && !q.scl_f;
	assign fall = !scl_n && q.scl_f;
	assign start = scl_n && q.scl_f && q.sda_f && !sda_n;
	assign stop = scl_n && q.scl_f && !q.sda_f && sda_n;
	assign load_rd = fall && ((q.st == SER_DEV_ACK && q.rw)
		|| (q.st == SER_RD_ACK && !q.nack));

	// Read value at the current pointer
	always_comb begin
		rd_byte = 8'h00;
		if (q.ptr == `OFS_SAMPLE_CTRL) begin
			rd_byte = q.sample_ctrl;
		end else if (in_range(q.ptr, `OFS_RESULT_FIRST, `OFS_RESULT_LAST)) begin
			rd_byte = res_rd;
		end else if (q.ptr == `OFS_FIFO_PORT) begin
			rd_byte = fifo_head;
		end else if (q.ptr == `OFS_CRAM_PORT) begin
			rd_byte = cram[q.cram_ptr];
		end else if (in_range(q.ptr, `OFS_LINE_FIRST, `OFS_LINE_LAST)) begin
			rd_byte = q.line_mode[6'(q.ptr - `OFS_LINE_FIRST)];
		end
	end

	always_comb begin
		d = q;
		cram_we = 1'b0;
		fifo_pop = 1'b0;
		d.scl_s = {q.scl_s[1:0], scl_i};
		d.sda_s = {q.sda_s[1:0], sda_i};
		d.scl_f = scl_n;
		d.sda_f = sda_n;
		d.slice_ctl = '{svc: cur_svc, code: cur_code};
		// Slicer keeps the RAM unless every line is switched off
		d.host_own = &q.line_mode;
		if (start) begin
			d.st = SER_DEV;
			d.bitcnt = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop) begin
			d.st = SER_IDLE;
			d.sda_oe = 1'b0;
		end else if (rise) begin
			case (q.st)
				SER_DEV, SER_REG, SER_WR: begin
					d.shreg = {q.shreg[6:0], sda_n};
					d.bitcnt = q.bitcnt + 4'h1;
				end
				SER_RD_ACK: begin
					d.nack = sda_n;
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			case (q.st)
				SER_DEV: begin
					if (q.bitcnt == 4'h8) begin
						if (q.shreg[7:1] == `DEV_ADDR) begin
							d.rw = q.shreg[0];
							d.sda_oe = 1'b1;
							d.st = SER_DEV_ACK;
						end else begin
							d.st = SER_IDLE;
						end
					end
				end
				SER_REG: begin
					if (q.bitcnt == 4'h8) begin
						d.ptr = q.shreg;
						d.sda_oe = 1'b1;
						d.st = SER_REG_ACK;
					end
				end
				SER_WR: begin
					if (q.bitcnt == 4'h8) begin
						d.sda_oe = 1'b1;
						d.st = SER_WR_ACK;
						if (q.ptr == `OFS_SAMPLE_CTRL) begin
							d.sample_ctrl = q.shreg;
						end else if (q.ptr == `OFS_CRAM_PORT) begin
							cram_we = 1'b1;
							d.cram_ptr = q.cram_ptr + 8'h01;
						end else if (in_range(q.ptr, `OFS_LINE_FIRST, `OFS_LINE_LAST)) begin
							d.line_mode[6'(q.ptr - `OFS_LINE_FIRST)] = q.shreg;
						end
						if (q.ptr != `OFS_CRAM_PORT && q.ptr != `OFS_FIFO_PORT) begin
							d.ptr = q.ptr + 8'h01;
						end
					end
				end
				SER_DEV_ACK, SER_RD_ACK: begin
					if (!load_rd) begin
						d.sda_oe = 1'b0;
						d.bitcnt = 4'h0;
						d.st = (q.st == SER_DEV_ACK) ? SER_REG : SER_IDLE;
					end
				end
				SER_REG_ACK, SER_WR_ACK: begin
					d.sda_oe = 1'b0;
					d.bitcnt = 4'h0;
					d.st = SER_WR;
				end
				SER_RD: begin
					if (q.bitcnt == 4'h8) begin
						d.sda_oe = 1'b0;
						d.st = SER_RD_ACK;
					end else begin
						d.sda_oe = !q.shreg[7];
						d.shreg = {q.shreg[6:0], 1'b0};
						d.bitcnt = q.bitcnt + 4'h1;
					end
				end
				default: begin
					d.st = SER_IDLE;
				end
			endcase
			// Byte fetched as its first bit goes out; port reads have side effects
			if (load_rd) begin
				d.sda_oe = !rd_byte[7];
				d.shreg = {rd_byte[6:0], 1'b0};
				d.bitcnt = 4'h1;
				d.st = SER_RD;
				if (q.ptr == `OFS_CRAM_PORT) begin
					d.cram_ptr = q.cram_ptr + 8'h01;
				end else if (q.ptr == `OFS_FIFO_PORT) begin
					fifo_pop = 1'b1;
				end else begin
					d.ptr = q.ptr + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.scl_s <= 3'b111;
			q.sda_s <= 3'b111;
			q.scl_f <= 1'b1;
			q.sda_f <= 1'b1;
			q.st <= SER_IDLE;
			q.cram_ptr <= 8'h00;
			q.sample_ctrl <= `SAMPLE_CTRL_RST;
			q.line_mode <= {`LINE_REGS{`LINE_MODE_RST}};
			q.slice_ctl <= '{svc: SVC_OFF, code: 4'h0};
			q.host_own <= 1'b1;
		end else if (clk_en_i) begin
			q <= d;
		end
	end

	// A slicer lookup at the address being written gets the old byte; slicer reads are one cycle late
	always_ff @(posedge clock_i) begin
		if (clk_en_i) begin
			if (cram_we) begin
				cram[q.cram_ptr] <= q.shreg;
			end
			cram_rdata_q <= cram[cram_raddr_i];
		end
	end

	assign sda_o = q.sda_out;
	assign sda_oe_o = q.sda_oe;
	assign slice_ctl_o = q.slice_ctl;
	assign cram_rdata_o = cram_rdata_q;
	assign cram_host_own_o = q.host_own;
endmodule

/* include/vbi_slicer_params.svh */
// Offsets, field positions, reset values and sizes of the VBI slicer host-access block
`ifndef VBI_SLICER_PARAMS_SVH
`define VBI_SLICER_PARAMS_SVH

// Serial port device address, arbitrary value
`define DEV_ADDR 7'h5D
`define OFS_SAMPLE_CTRL 8'h0D
`define OFS_RESULT_FIRST 8'h90
`define OFS_RESULT_LAST 8'hAF
`define OFS_FIFO_PORT 8'hB0
`define OFS_CRAM_PORT 8'hC3
`define OFS_LINE_FIRST 8'hD0
`define OFS_LINE_LAST 8'hFC
`define SAMPLE_BIT 7
`define SAMPLE_CTRL_RST 8'h00
`define LINE_MODE_OFF 8'hFF
`define LINE_MODE_RST 8'hFF
`define LINE_REGS 45
`define VBI_LINE_FIRST 10'h006
`define VBI_LINE_LAST 10'h01B
`define VBI_LINES_PER_FIELD 6'h16
`define CODE_TT_LAST 4'h5
`define CODE_DATA_LAST 4'hC
`define CODE_FULL 4'hF
`define CRAM_DEPTH 256
`define FIFO_DEPTH 512
`define RESULT_REGS 32

`endif

/* include/vbi_slicer_pkg.sv */
// Types shared by the VBI slicer host-access block
package vbi_slicer_pkg;

	typedef enum logic [2:0] {
		SVC_OFF = 3'b000,
		SVC_TELETEXT = 3'b001,
		SVC_REGDATA = 3'b010,
		SVC_FULL = 3'b011,
		SVC_RESERVED = 3'b100
	} svc_e;

	typedef enum logic [3:0] {
		SER_IDLE = 4'b0000,
		SER_DEV = 4'b0001,
		SER_DEV_ACK = 4'b0010,
		SER_REG = 4'b0011,
		SER_REG_ACK = 4'b0100,
		SER_WR = 4'b0101,
		SER_WR_ACK = 4'b0110,
		SER_RD = 4'b0111,
		SER_RD_ACK = 4'b1000
	} ser_state_e;

	typedef struct packed {
		logic field;
		logic [9:0] line;
	} vpos_s;

	typedef struct packed {
		logic valid;
		logic [4:0] offset;
		logic [7:0] data;
	} beat_s;

	typedef struct packed {
		svc_e svc;
		logic [3:0] code;
	} slice_ctl_s;

endpackage

/* logic/slicer_result_store.sv */
// Sliced-result FIFO and dedicated result registers
`timescale 1ns/1ns
`include "vbi_slicer_params.svh"

module slicer_result_store (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic wr_fifo_i,
	input wire logic wr_reg_i,
	input wire logic [4:0] reg_idx_i,
	input wire logic [7:0] data_i,
	input wire logic [4:0] reg_ra_i,
	output logic [7:0] reg_rd_o,
	input wire logic fifo_pop_i,
	output logic [7:0] fifo_head_o,
	output logic fifo_empty_o
);
	typedef struct packed {
		logic [9:0] wp;
		logic [9:0] rp;
	} store_s;

	store_s q, d;
	logic [7:0] fifo_mem [`FIFO_DEPTH];
	logic [7:0] result_mem [`RESULT_REGS];
	logic full, empty, push;

	assign empty = q.wp == q.rp;
	assign full = (q.wp[8:0] == q.rp[8:0]) && (q.wp[9] != q.rp[9]);
	// Full FIFO drops new bytes rather than overwriting unread ones
	assign push = wr_fifo_i && !full;
	assign fifo_empty_o = empty;
	assign fifo_head_o = empty ? 8'h00 : fifo_mem[q.rp[8:0]];
	assign reg_rd_o = result_mem[reg_ra_i];

	always_comb begin
		d = q;
		if (push) begin
			d.wp = q.wp + 10'h001;
		end
		if (fifo_pop_i && !empty) begin
			d.rp = q.rp + 10'h001;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else if (clk_en_i) begin
			q <= d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (clk_en_i) begin
			if (push) begin
				fifo_mem[q.wp[8:0]] <= data_i;
			end
			if (wr_reg_i) begin
				result_mem[reg_idx_i] <= data_i;
			end
		end
	end
endmodule

/* verif/vbi_slicer_config_access_monitor.sv */
// Port-level assertions for the VBI slicer host-access block
`timescale 1ns/1ns
`include "vbi_slicer_params.svh"
module vbi_slicer_config_access_monitor
	import vbi_slicer_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire vbi_slicer_pkg::vpos_s vpos_i,
	input wire vbi_slicer_pkg::slice_ctl_s slice_ctl_o,
	input wire logic cram_host_own_o
);
	import vbi_slicer_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence line_outside;
		clk_en_i && (vpos_i.line < 10'h006 || vpos_i.line > 10'h01B);
	endsequence
	// Line regs come out of reset as off, and no host write lands this soon
	sequence own_held;
		cram_host_own_o [*4];
	endsequence
	sda_open_a: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	out_range_a: assert property (line_outside |=> slice_ctl_o.svc == SVC_OFF)
		else $error("line outside slicing range not off");
	tt_code_a: assert property (slice_ctl_o.svc == SVC_TELETEXT |-> slice_ctl_o.code <= 4'h5)
		else $error("teletext with wrong code");
	regdata_code_a: assert property (slice_ctl_o.svc == SVC_REGDATA |->
		slice_ctl_o.code inside {[4'h6:4'hC]}) else $error("register service with wrong code");
	full_code_a: assert property (slice_ctl_o.svc == SVC_FULL |-> slice_ctl_o.code == 4'hF)
		else $error("full field with wrong code");
	reserved_code_a: assert property (slice_ctl_o.code inside {4'hD, 4'hE} |->
		slice_ctl_o.svc inside {SVC_RESERVED, SVC_OFF}) else $error("reserved code sliced");
	reset_own_a: assert property ($rose(rstn_i) |-> own_held)
		else $error("line regs not off after reset");
	oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data drive changed while clock high");
endmodule
bind vbi_slicer_config_access vbi_slicer_config_access_monitor u_monitor (.clock_i, .rstn_i,
	.clk_en_i, .scl_i, .sda_o, .sda_oe_o, .vpos_i, .slice_ctl_o, .cram_host_own_o);

/* verif/serial_host_model.sv */
// Serial control port host: open-drain master, data line pulled up
`timescale 1ns/1ns
`include "vbi_slicer_params.svh"
module serial_host_model (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic drv(input logic c, input logic d, input int n);
		scl_o <= c;
		sda_o <= d;
		repeat (n) @(posedge clock_i);
	endtask
	// Data moves mid-low so it never races the clock fall through the synchronisers
	task automatic bit_x(input logic b, output logic r);
		drv(1'b0, sda_o, 5);
		drv(1'b0, b, 5);
		drv(1'b1, b, 5);
		r = sda_i;
		repeat (5) @(posedge clock_i);
	endtask
	task automatic start();
		drv(1'b0, sda_o, 5);
		drv(1'b0, 1'b1, 5);
		drv(1'b1, 1'b1, 10);
		drv(1'b1, 1'b0, 10);
	endtask
	task automatic byte_x(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
		bit_x(a, k);
	endtask
	task automatic xfer(input logic [7:0] a, d, input logic rd, output logic [7:0] q,
		output logic nak);
		logic [7:0] t;
		logic k;
		start();
		byte_x({`DEV_ADDR, 1'b0}, 1'b1, t, nak);
		byte_x(a, 1'b1, t, k);
		nak |= k;
		if (rd) begin
			start();
			byte_x({`DEV_ADDR, 1'b1}, 1'b1, t, k);
			nak |= k;
			byte_x(8'hFF, 1'b1, q, k);
		end else begin
			byte_x(d, 1'b1, t, k);
			nak |= k;
		end
		drv(1'b0, sda_o, 5);
		drv(1'b0, 1'b0, 5);
		drv(1'b1, 1'b0, 10);
		drv(1'b1, 1'b1, 10);
	endtask
endmodule

/* verif/vbi_slicer_config_access_tb.sv */
// Self-checking bench for the VBI slicer host-access block
`timescale 1ns/1ns
`include "vbi_slicer_params.svh"
module vbi_slicer_config_access_tb;
	import vbi_slicer_pkg::*;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic scl, hsda, sda_o, sda_oe_o, own;
	wire logic sda_w = hsda & (sda_oe_o ? sda_o : 1'b1);
	vpos_s vpos_i = '{1'b0, 10'd10};
	beat_s beat_i = '0;
	slice_ctl_s ctl;
	logic [7:0] raddr = 8'h00;
	logic [7:0] rdata;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	vbi_slicer_config_access u_vbi_slicer_config_access (.clock_i, .rstn_i, .clk_en_i,
		.scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_o, .vpos_i, .beat_i, .slice_ctl_o(ctl),
		.cram_raddr_i(raddr), .cram_rdata_o(rdata), .cram_host_own_o(own));
	serial_host_model u_serial_host_model (.clock_i, .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
	initial begin
		forever #2 clock_i = ~clock_i;
	end
	task automatic close_out();
		if (failures == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			failures++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		logic n;
		u_serial_host_model.xfer(a, d, 1'b0, q, n);
		chk({7'h00, n}, 8'h00);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		logic [7:0] q;
		logic n;
		u_serial_host_model.xfer(a, 8'h00, 1'b1, q, n);
		chk({7'h00, n}, 8'h00);
		chk(q, exp);
	endtask
	task automatic do_reset();
		rstn_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (8) @(posedge clock_i);
	endtask
	function automatic logic [7:0] svc_for(input logic [3:0] c, input logic s);
		if (c == `CODE_FULL) return {5'h00, SVC_FULL};
		if (!s || c > `CODE_DATA_LAST) return {5'h00, SVC_RESERVED};
		return {5'h00, (c <= `CODE_TT_LAST) ? SVC_TELETEXT : SVC_REGDATA};
	endfunction
	task automatic t_modes();
		for (int s = 0; s < 2; s++) begin
			wr(`OFS_SAMPLE_CTRL, s[0] ? 8'h80 : 8'h00);
			for (int c = 0; c < 16; c++) begin
				wr(8'hD4, {4'h0, c[3:0]});
				@(negedge clock_i);
				chk({5'h00, ctl.svc}, svc_for(c[3:0], s[0]));
				chk({4'h0, ctl.code}, {4'h0, c[3:0]});
				@(posedge clock_i);
			end
		end
	endtask
	task automatic t_lines();
		vpos_s p[5] = '{'{1'b0, 10'd5}, '{1'b0, 10'd6}, '{1'b0, 10'd27}, '{1'b1, 10'd6},
			'{1'b1, 10'd28}};
		logic [2:0] e[5] = '{SVC_OFF, SVC_REGDATA, SVC_REGDATA, SVC_REGDATA, SVC_OFF};
		wr(8'hD0, 8'h07);
		wr(8'hE5, 8'h07);
		wr(8'hE6, 8'h07);
		for (int i = 0; i < 5; i++) begin
			@(posedge clock_i);
			vpos_i <= p[i];
			repeat (2) @(negedge clock_i);
			chk({5'h00, ctl.svc}, {5'h00, e[i]});
		end
		@(posedge clock_i);
		vpos_i <= '{1'b0, 10'd10};
	endtask
	task automatic beat(input logic [7:0] d);
		@(posedge clock_i);
		beat_i <= '{1'b1, 5'd3, d};
		@(posedge clock_i);
		beat_i <= '0;
	endtask
	// Same offset each time, so a stray teletext write would overwrite 93h
	task automatic t_results();
		wr(8'hD4, 8'h07);
		beat(8'h55);
		wr(8'hD4, 8'h01);
		beat(8'h66);
		wr(8'hD4, 8'h0D);
		beat(8'h77);
		rd(8'h93, 8'h55);
		rd(`OFS_FIFO_PORT, 8'h55);
		rd(`OFS_FIFO_PORT, 8'h66);
		rd(`OFS_FIFO_PORT, 8'h00);
		rd(8'h10, 8'h00);
		rd(`OFS_SAMPLE_CTRL, 8'h80);
		rd(8'hD4, 8'h0D);
	endtask
	// Clock enable low must freeze the registered service
	task automatic t_hold();
		@(posedge clock_i);
		clk_en_i <= 1'b0;
		vpos_i <= '{1'b0, 10'd5};
		repeat (3) @(negedge clock_i);
		chk({5'h00, ctl.svc}, {5'h00, SVC_RESERVED});
		@(posedge clock_i);
		clk_en_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		chk({5'h00, ctl.svc}, {5'h00, SVC_OFF});
		@(posedge clock_i);
		vpos_i <= '{1'b0, 10'd10};
	endtask
	task automatic t_cram();
		for (int i = 0; i < `LINE_REGS; i++) wr(`OFS_LINE_FIRST + 8'(i), 8'hFF);
		chk({7'h00, own}, 8'h01);
		wr(`OFS_CRAM_PORT, 8'hA1);
		wr(`OFS_CRAM_PORT, 8'hB2);
		for (int i = 0; i < 2; i++) begin
			@(posedge clock_i);
			raddr <= 8'(i);
			repeat (2) @(negedge clock_i);
			chk(rdata, i ? 8'hB2 : 8'hA1);
		end
		@(posedge clock_i);
		do_reset();
		rd(`OFS_CRAM_PORT, 8'hA1);
		rd(`OFS_CRAM_PORT, 8'hB2);
	endtask
	initial begin
		@(posedge clock_i);
		do_reset();
		t_modes();
		t_lines();
		t_results();
		t_hold();
		t_cram();
		close_out();
	end
endmodule
